/* design/mst_pkg.sv */
// Package with constants, types and the current table of the microstep translator.
`default_nettype none

package mst_pkg;

  // Clock and timing.
  localparam int CLK_MHZ              = 125;
  localparam int FIXED_OFF_TIME_US    = 30;
  localparam int OFF_TIME_CYC         = FIXED_OFF_TIME_US * CLK_MHZ;
  localparam int SENSE_BLANK_TIME_NS  = 1000;
  localparam int BLANK_CYC            = (SENSE_BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W                = 24;
  localparam int OFF_US_W             = 16;

  // Fast-decay share of the off-time is FAST_NUM / 2**FAST_SHIFT = 5/16 = 31.25 %.
  localparam int FAST_NUM             = 5;
  localparam int FAST_SHIFT           = 4;

  // Translator geometry: 32 positions per electrical cycle, home at 45 degrees.
  localparam int          POS_W       = 5;
  localparam logic [4:0]  HOME_POS    = 5'h04;
  localparam logic [4:0]  QUARTER_POS = 5'h08;
  localparam logic [3:0]  HALF_TURN   = 4'h8;
  localparam logic [4:0]  WRAP_POS    = 5'h10;

  // Register map, byte addresses on the Avalon slave.
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  STATUS_OFS  = 4'h4;
  localparam logic [3:0]  PHASE_OFS   = 4'h8;
  localparam logic [3:0]  CHOP_OFS    = 4'hc;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {RES_FULL, RES_HALF, RES_QUARTER, RES_EIGHTH} mst_res_t;
  typedef enum logic [1:0] {OTM_VDD, OTM_GND, OTM_RES, OTM_RES_ALT} mst_otm_t;
  typedef enum logic [1:0] {CH_DRIVE, CH_FAST, CH_SLOW} mst_chop_t;
  typedef enum logic {DEC_SLOW, DEC_MIXED} mst_decay_t;

  typedef struct packed {
    logic [6:0] level;
    logic       pol;
    mst_decay_t decay;
  } mst_phase_t;

  typedef struct packed {
    logic src_a;
    logic snk_a;
    logic src_b;
    logic snk_b;
  } mst_gate_t;

  typedef struct packed {
    logic [14:0]  zero;
    logic [3:0]   flags;
    mst_otm_t     otm;
    mst_res_t     res;
    logic         dir;
    logic [2:0]   pad;
    logic [4:0]   pos;
  } mst_status_t;

  typedef struct packed {
    logic [13:0]  zero;
    mst_phase_t   ph1;
    mst_phase_t   ph0;
  } mst_phase_word_t;

  typedef struct packed {
    logic [19:0]  zero;
    mst_gate_t    gate1;
    mst_gate_t    gate0;
    mst_chop_t    chop1;
    mst_chop_t    chop0;
  } mst_chop_word_t;

  // Percent of full scale for sin(k * 11.25 deg), k = 0..8.
  function automatic logic [6:0] mst_sin_pct(input logic [3:0] k);
    case (k)
      4'h0:    mst_sin_pct = 7'h00;
      4'h1:    mst_sin_pct = 7'h14;
      4'h2:    mst_sin_pct = 7'h26;
      4'h3:    mst_sin_pct = 7'h38;
      4'h4:    mst_sin_pct = 7'h47;
      4'h5:    mst_sin_pct = 7'h53;
      4'h6:    mst_sin_pct = 7'h5c;
      4'h7:    mst_sin_pct = 7'h62;
      default: mst_sin_pct = 7'h64;
    endcase
  endfunction : mst_sin_pct

endpackage : mst_pkg

`default_nettype wire

/* design/mst_translator.sv */
// Microstep translator with decay selection, fixed off-time chopper and Avalon-MM status port.
//
// How it works
// - reset loads home position, both phases Mixed
// - step rising edge advances one resolution increment
// - falling phase level selects Mixed decay
// - rising or equal level selects Slow decay
// - resolution pins decode full, half, quarter, eighth
// - resolution change applies only at step edge
// - thermal or overcurrent event returns translator home
// - Mixed off-time: fast 31.25 percent, then slow
// - off-time pin grounded: Mixed decay except in full step
// - off-time pin grounded: fixed 30 us off-time
// - reset pin low: home, all drivers off
// - reset pin low: step edges are ignored
// - direction change applies only at step edge
// - drive diagonal pair, comparator trip ends drive
// - Slow drops source only, Mixed drops both
// - output per-phase level as percent of full scale
// - off-time pin high: 30 us, auto, full-step Slow
// - grounded pin still forces Slow in full step
// - resistor mode: programmed off-time, auto decay always
// - one-shot holds decay for whole off-time
// - comparator ignored for 1 us after switching
// - enable high disables drivers, sequencing continues
//
// Implementation choices: register access over Avalon-MM and the address map.
`default_nettype none

module mst_translator
  import mst_pkg::*;
#(
  parameter int RESET_OFF_US = FIXED_OFF_TIME_US
) (
  // Clock and reset.
  input  wire  logic                   sys_clk,
  input  wire  logic                   sys_rst,
  // Host pins, asynchronous to sys_clk.
  input  wire  logic                   step,
  input  wire  logic                   dir,
  input  wire  logic                   resolution_sel_0,
  input  wire  logic                   resolution_sel_1,
  input  wire  logic                   reset_n,
  input  wire  logic                   enable_n,
  // Off-time configuration pin state, coded as mst_otm_t.
  input  wire  logic [1:0]             off_time_config_pin,
  // Fault events and current-sense comparators.
  input  wire  logic                   thermal_shutdown_event,
  input  wire  logic                   overcurrent_event,
  input  wire  logic [1:0]             sense_trip,
  // Avalon-MM slave.
  input  wire  logic [ADDR_W-1:0]      avs_address,
  input  wire  logic                   avs_read,
  input  wire  logic                   avs_write,
  input  wire  logic [31:0]            avs_writedata,
  input  wire  logic [3:0]             avs_byteenable,
  output var   logic [31:0]            avs_readdata,
  output var   logic                   avs_waitrequest,
  // Bridge outputs.
  output var   mst_phase_t [1:0]       phase_out,
  output var   mst_gate_t  [1:0]       bridge_gate
);

  localparam int PIN_W = 13;

  // Two-flop synchronisers for every pin; only stage two is read by logic.
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic             step_d_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {step, dir, resolution_sel_1, resolution_sel_0, reset_n, enable_n, off_time_config_pin,
                   thermal_shutdown_event, overcurrent_event, sense_trip, 1'b0};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic       step_s;
  logic       dir_s;
  logic [1:0] ms_s;
  logic       rst_pin_s;
  logic       enable_n_s;
  mst_otm_t   otm_s;
  logic       tsd_s;
  logic       ocp_s;
  logic [1:0] trip_s;
  logic       unused_s;

  assign {step_s, dir_s, ms_s, rst_pin_s, enable_n_s} = pin_s2_r[PIN_W-1:PIN_W-6];
  assign otm_s    = mst_otm_t'(pin_s2_r[6:5]);
  assign tsd_s    = pin_s2_r[4];
  assign ocp_s    = pin_s2_r[3];
  assign trip_s   = pin_s2_r[2:1];
  assign unused_s = pin_s2_r[0];

  // Reset pin is active low, so it reads low until the synchroniser fills.
  logic pin_reset;
  logic home_req;
  logic step_rise;
  logic drive_ok;

  assign pin_reset = ~rst_pin_s;
  assign home_req  = sys_rst | pin_reset | tsd_s | ocp_s;
  assign step_rise = step_s & ~step_d_r & ~pin_reset;
  assign drive_ok  = ~pin_reset & ~enable_n_s & ~tsd_s & ~ocp_s & ~unused_s;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      step_d_r <= 1'b0;
    end else begin
      step_d_r <= step_s;
    end
  end

  // Translator position; direction and resolution are captured only at a step edge.
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic [POS_W-1:0] pos_inc;
  mst_res_t         res_r;
  mst_res_t         res_sel;
  logic             dir_r;

  assign res_sel = mst_res_t'(ms_s);

  always_comb begin
    case (res_sel)
      RES_FULL:    pos_inc = QUARTER_POS;
      RES_HALF:    pos_inc = QUARTER_POS >> 1;
      RES_QUARTER: pos_inc = QUARTER_POS >> 2;
      default:     pos_inc = QUARTER_POS >> 3;
    endcase
    pos_nxt = dir_s ? POS_W'(pos_r + pos_inc) : POS_W'(pos_r - pos_inc);
  end

  always_ff @(posedge sys_clk) begin
    if (home_req) begin
      pos_r <= HOME_POS;
    end else if (step_rise) begin
      pos_r <= pos_nxt;
    end
  end

  // Home is common to all resolutions, so the captured mode survives a pin or fault home request.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      res_r <= RES_FULL;
      dir_r <= 1'b0;
    end else if (step_rise) begin
      res_r <= res_sel;
      dir_r <= dir_s;
    end
  end

  // Phase 0 follows cos, phase 1 follows sin of the position angle.
  function automatic mst_phase_t phase_of(input logic [POS_W-1:0] p, input logic second);
    logic [POS_W-1:0] idx;
    logic [3:0]       k;
    idx = second ? p : POS_W'(p + QUARTER_POS);
    k   = (idx[3:0] <= HALF_TURN) ? idx[3:0] : 4'((WRAP_POS - {1'b0, idx[3:0]}));
    phase_of.level = mst_sin_pct(k);
    phase_of.pol   = ~idx[4];
    phase_of.decay = DEC_MIXED;
  endfunction : phase_of

  // Off-time selection from the configuration pin and the programmed value.
  logic [OFF_US_W-1:0] off_us_r;
  logic [CNT_W-1:0]    off_cyc_r;
  logic [CNT_W-1:0]    fast_cyc_r;
  logic [CNT_W-1:0]    off_cyc_nxt;
  logic [CNT_W+2:0]    fast_prod;
  logic                res_mode;

  assign res_mode = (otm_s == OTM_RES) || (otm_s == OTM_RES_ALT);

  always_comb begin
    if (res_mode) begin
      off_cyc_nxt = CNT_W'(off_us_r * CLK_MHZ);
    end else begin
      off_cyc_nxt = CNT_W'(OFF_TIME_CYC);
    end
    if (off_cyc_nxt == '0) begin
      off_cyc_nxt = CNT_W'(1);
    end
    fast_prod = (CNT_W+3)'(off_cyc_r) * (CNT_W+3)'(FAST_NUM);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      off_cyc_r  <= CNT_W'(OFF_TIME_CYC);
      fast_cyc_r <= CNT_W'((OFF_TIME_CYC * FAST_NUM) >> FAST_SHIFT);
    end else begin
      off_cyc_r  <= off_cyc_nxt;
      fast_cyc_r <= CNT_W'(fast_prod >> FAST_SHIFT);
    end
  end

  // Per-phase level, decay choice and chopper.
  mst_chop_t [1:0] chop_r;

  for (genvar ph = 0; ph < 2; ph++) begin : g_phase
    mst_phase_t       next_ph;
    mst_decay_t       auto_decay;
    mst_chop_t        chop_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    mst_gate_t        gate_nxt;

    assign next_ph    = phase_of(pos_nxt, ph == 1);
    assign auto_decay = (next_ph.level < phase_out[ph].level) ? DEC_MIXED : DEC_SLOW;

    always_ff @(posedge sys_clk) begin
      if (home_req) begin
        phase_out[ph] <= phase_of(HOME_POS, ph == 1);
      end else if (step_rise) begin
        phase_out[ph].level <= next_ph.level;
        phase_out[ph].pol   <= next_ph.pol;
        if (res_sel == RES_FULL && !res_mode) begin
          phase_out[ph].decay <= DEC_SLOW;
        end else if (otm_s == OTM_GND) begin
          phase_out[ph].decay <= DEC_MIXED;
        end else begin
          phase_out[ph].decay <= auto_decay;
        end
      end
    end

    // The same counter times blanking in drive and the off-time one-shot in decay.
    always_comb begin
      chop_nxt = chop_r[ph];
      cnt_nxt  = CNT_W'(cnt_r + 1'b1);
      case (chop_r[ph])
        CH_DRIVE: begin
          if (cnt_r < CNT_W'(BLANK_CYC - 1)) begin
            chop_nxt = CH_DRIVE;
          end else if (trip_s[ph]) begin
            chop_nxt = (phase_out[ph].decay == DEC_MIXED && fast_cyc_r != '0) ? CH_FAST : CH_SLOW;
            cnt_nxt  = '0;
          end else begin
            cnt_nxt  = cnt_r;
          end
        end
        CH_FAST: begin
          if (cnt_r >= fast_cyc_r - 1'b1) begin
            chop_nxt = CH_SLOW;
          end
        end
        CH_SLOW: begin
          if (cnt_r >= off_cyc_r - 1'b1) begin
            chop_nxt = CH_DRIVE;
            cnt_nxt  = '0;
          end
        end
        default: begin
          chop_nxt = CH_DRIVE;
          cnt_nxt  = '0;
        end
      endcase
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        chop_r[ph] <= CH_DRIVE;
        cnt_r      <= '0;
      end else begin
        chop_r[ph] <= chop_nxt;
        cnt_r      <= cnt_nxt;
      end
    end

    // Fast decay leaves all four off and lets the body diodes return current to the supply.
    always_comb begin
      gate_nxt = '0;
      case (chop_r[ph])
        CH_DRIVE: begin
          gate_nxt.src_a = phase_out[ph].pol;
          gate_nxt.snk_b = phase_out[ph].pol;
          gate_nxt.src_b = ~phase_out[ph].pol;
          gate_nxt.snk_a = ~phase_out[ph].pol;
        end
        CH_SLOW: begin
          gate_nxt.snk_b = phase_out[ph].pol;
          gate_nxt.snk_a = ~phase_out[ph].pol;
        end
        default: begin
          gate_nxt = '0;
        end
      endcase
      if (!drive_ok) begin
        gate_nxt = '0;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        bridge_gate[ph] <= '0;
      end else begin
        bridge_gate[ph] <= gate_nxt;
      end
    end
  end

  // Avalon-MM slave: one wait cycle, then the access completes with waitrequest low.
  logic            bus_req;
  logic            bus_done;
  logic [31:0]     rd_nxt;
  mst_status_t     status_w;
  mst_phase_word_t phase_w;
  mst_chop_word_t  chop_w;

  assign bus_req  = avs_read | avs_write;
  assign bus_done = bus_req & ~avs_waitrequest;

  always_comb begin
    status_w       = '0;
    status_w.pos   = pos_r;
    status_w.dir   = dir_r;
    status_w.res   = res_r;
    status_w.otm   = otm_s;
    status_w.flags = {drive_ok, ocp_s, tsd_s, pin_reset};
    phase_w        = '0;
    phase_w.ph0    = phase_out[0];
    phase_w.ph1    = phase_out[1];
    chop_w         = '0;
    chop_w.chop0   = chop_r[0];
    chop_w.chop1   = chop_r[1];
    chop_w.gate0   = bridge_gate[0];
    chop_w.gate1   = bridge_gate[1];
    case (avs_address)
      CTRL_OFS:   rd_nxt = {{(32-OFF_US_W){1'b0}}, off_us_r};
      STATUS_OFS: rd_nxt = status_w;
      PHASE_OFS:  rd_nxt = phase_w;
      CHOP_OFS:   rd_nxt = chop_w;
      default:    rd_nxt = READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= READ_ZERO;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_nxt : READ_ZERO;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Programmed off-time in microseconds, used only in resistor mode.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      off_us_r <= OFF_US_W'(RESET_OFF_US);
    end else if (bus_done && avs_write && avs_address == CTRL_OFS) begin
      if (avs_byteenable[0]) begin
        off_us_r[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        off_us_r[15:8] <= avs_writedata[15:8];
      end
    end
  end

endmodule : mst_translator

`default_nettype wire

/* tb/mst_translator_monitor.sv */
// Port-level assertions for the microstep translator, bound into the design.
`default_nettype none

module mst_translator_monitor
  import mst_pkg::*;
(
  // Clock and reset.
  input wire logic             sys_clk,
  input wire logic             sys_rst,
  // Host pins and fault inputs.
  input wire logic             reset_n,
  input wire logic             enable_n,
  input wire logic             thermal_shutdown_event,
  input wire logic [1:0]       sense_trip,
  // Bus handshake.
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic             avs_waitrequest,
  // Bridge outputs.
  input wire mst_phase_t [1:0] phase_out,
  input wire mst_gate_t  [1:0] bridge_gate
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Pin changes pass a two-flop synchroniser, so the counts below allow for it.
  chk_reset_home: assert property ($fell(sys_rst) |-> phase_out[0] == {7'h47, 1'b1, DEC_MIXED}
    && phase_out[1] == {7'h47, 1'b1, DEC_MIXED}) else $error("phase outputs not at home after reset");
  chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  chk_wait_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_pin_reset_off: assert property (!reset_n [*4] |-> bridge_gate == '0
    && phase_out[0].level == 7'h47 && phase_out[1].level == 7'h47) else $error("reset pin low but not home");
  chk_steps_ignored: assert property (!reset_n [*6] |=> $stable(phase_out))
    else $error("phase moved while reset pin low");
  chk_disable_off: assert property (enable_n [*4] |-> bridge_gate == '0)
    else $error("gates driven while disabled");
  chk_fault_home: assert property (thermal_shutdown_event [*5] |-> bridge_gate == '0
    && phase_out[0].level == 7'h47 && phase_out[1].level == 7'h47) else $error("fault did not return home");
  chk_diagonal_pair: assert property ((!bridge_gate[0].src_a || bridge_gate[0].snk_b)
    && (!bridge_gate[0].src_b || bridge_gate[0].snk_a)) else $error("source without diagonal sink");
  chk_slow_keep_sink: assert property ($fell(bridge_gate[0].src_a) && $past(sense_trip[0], 3)
    && phase_out[0].decay == DEC_SLOW && reset_n && !enable_n |-> bridge_gate[0].snk_b)
    else $error("slow decay dropped the sink");
  chk_mixed_drop_both: assert property ($fell(bridge_gate[0].src_a) && $past(sense_trip[0], 3)
    && phase_out[0].decay == DEC_MIXED && reset_n && !enable_n |-> bridge_gate[0] == '0)
    else $error("mixed decay kept a driver on");

  cov_trip: cover property ($fell(bridge_gate[0].src_a));
  cov_read: cover property (avs_read && !avs_waitrequest);
  cov_step: cover property ($changed(phase_out[0].level));

endmodule : mst_translator_monitor

bind mst_translator mst_translator_monitor u_mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_n(reset_n), .enable_n(enable_n),
  .thermal_shutdown_event(thermal_shutdown_event), .sense_trip(sense_trip), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .phase_out(phase_out), .bridge_gate(bridge_gate)
);

`default_nettype wire

/* tb/mst_host_model.sv */
// Behavioural host controller that drives the step, direction, resolution and reset pins.
`default_nettype none

module mst_host_model (
  // Clock.
  input  wire logic sys_clk,
  // Translator pins.
  output var  logic step,
  output var  logic dir,
  output var  logic resolution_sel_0,
  output var  logic resolution_sel_1,
  output var  logic reset_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    step = 1'b0;
    dir = 1'b1;
    {resolution_sel_1, resolution_sel_0} = 2'h0;
    reset_n = 1'b1;
  end

  // Callers only change resolution at a position common to old and new modes.
  task automatic set_mode(input logic d, input logic [1:0] r);
    @(posedge sys_clk);
    dir <= d;
    {resolution_sel_1, resolution_sel_0} <= r;
    repeat (4) @(posedge sys_clk);
  endtask : set_mode

  task automatic pulse();
    @(posedge sys_clk);
    step <= 1'b1;
    repeat (4) @(posedge sys_clk);
    step <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic hold_reset(input logic v);
    @(posedge sys_clk);
    reset_n <= v;
  endtask : hold_reset

endmodule : mst_host_model

`default_nettype wire

/* tb/mst_translator_bench.sv */
// Self-checking bench for the microstep translator.
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module mst_translator_bench
  import mst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] PCT [9] = '{7'h00, 7'h14, 7'h26, 7'h38, 7'h47, 7'h53, 7'h5c, 7'h62, 7'h64};

  logic             sys_clk, sys_rst, enable_n, thermal_shutdown_event, overcurrent_event;
  logic             step, dir, resolution_sel_0, resolution_sel_1, reset_n;
  logic [1:0]       otm, sense_trip;
  logic [3:0]       avs_address, avs_byteenable;
  logic             avs_read, avs_write, avs_waitrequest;
  logic [31:0]      avs_writedata, avs_readdata, rd;
  mst_phase_t [1:0] phase_out;
  mst_gate_t  [1:0] bridge_gate;
  logic [4:0]       exp_pos;
  int               mismatches = 0;
  int               tests_run = 0;
  int               cyc = 0;

  mst_host_model host (.sys_clk(sys_clk), .step(step), .dir(dir), .resolution_sel_0(resolution_sel_0),
    .resolution_sel_1(resolution_sel_1), .reset_n(reset_n));

  mst_translator uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .step(step), .dir(dir),
    .resolution_sel_0(resolution_sel_0), .resolution_sel_1(resolution_sel_1), .reset_n(reset_n),
    .enable_n(enable_n), .off_time_config_pin(otm), .thermal_shutdown_event(thermal_shutdown_event),
    .overcurrent_event(overcurrent_event), .sense_trip(sense_trip), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .phase_out(phase_out),
    .bridge_gate(bridge_gate));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Phase 0 follows cosine, phase 1 sine, in 11.25 degree steps.
  function automatic logic [6:0] lvl(input int ph, input logic [4:0] p);
    int k;
    k = (p[3:0] > 8) ? p[3:0] - 8 : 8 - p[3:0];
    return PCT[ph ? 8 - k : k];
  endfunction : lvl

  function automatic mst_decay_t dk(input logic [1:0] r, input logic [6:0] n, input logic [6:0] o);
    if (r == RES_FULL && otm != OTM_RES && otm != OTM_RES_ALT) return DEC_SLOW;
    if (otm == OTM_GND) return DEC_MIXED;
    return (n < o) ? DEC_MIXED : DEC_SLOW;
  endfunction : dk

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic do_reset(input logic [1:0] m);
    otm <= m;
    sys_rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    exp_pos = HOME_POS;
  endtask : do_reset

  task automatic step_chk(input logic d, input logic [1:0] r);
    logic [4:0] p0;
    p0 = exp_pos;
    host.set_mode(d, r);
    bus(1'b0, STATUS_OFS, '0, rd);
    `CHK("held pos", p0, rd[4:0])
    host.pulse();
    exp_pos = d ? exp_pos + (5'h08 >> r) : exp_pos - (5'h08 >> r);
    bus(1'b0, STATUS_OFS, '0, rd);
    `CHK("position", exp_pos, rd[4:0])
    `CHK("captured res", r, rd[10:9])
    `CHK("cos level", lvl(0, exp_pos), phase_out[0].level)
    `CHK("sin level", lvl(1, exp_pos), phase_out[1].level)
    `CHK("cos decay", dk(r, lvl(0, exp_pos), lvl(0, p0)), phase_out[0].decay)
    `CHK("sin decay", dk(r, lvl(1, exp_pos), lvl(1, p0)), phase_out[1].decay)
    if (lvl(0, exp_pos) != 0) `CHK("cos pol", exp_pos < 8 || exp_pos > 24, phase_out[0].pol)
    if (lvl(1, exp_pos) != 0) `CHK("sin pol", exp_pos < 16, phase_out[1].pol)
    bus(1'b0, PHASE_OFS, '0, rd);
    `CHK("sin word", lvl(1, exp_pos), rd[17:11])
  endtask : step_chk

  // Trip phase 0 and time the fast and slow parts of the off-time, then the blanking window.
  task automatic meas_off(input int f, input int s);
    int nf, ns, nb;
    nf = 0;
    ns = 0;
    nb = 0;
    bus(1'b0, CHOP_OFS, '0, rd);
    `CHK("chop word", 12'h990, rd[11:0])
    `CHK("drive pair", 4'h9, bridge_gate[0])
    sense_trip[0] <= 1'b1;
    while (bridge_gate[0] === 4'h9) @(posedge sys_clk);
    sense_trip[0] <= 1'b0;
    while (bridge_gate[0] === 4'h0) begin nf++; @(posedge sys_clk); end
    `CHK("slow pattern", 4'h1, bridge_gate[0])
    while (bridge_gate[0] === 4'h1) begin ns++; @(posedge sys_clk); end
    `CHK("fast cycles", f, nf)
    `CHK("slow cycles", s, ns)
    sense_trip[0] <= 1'b1;
    while (bridge_gate[0] === 4'h9) begin nb++; @(posedge sys_clk); end
    sense_trip[0] <= 1'b0;
    `CHK("blanking", 1'b1, nb >= BLANK_CYC)
    // The blanking trip starts another off-time; let it run out so the next call starts in drive.
    while (bridge_gate[0] !== 4'h9) @(posedge sys_clk);
  endtask : meas_off

  task automatic t_fault();
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      if (i == 0) thermal_shutdown_event <= 1'b1;
      else overcurrent_event <= 1'b1;
      repeat (6) @(posedge sys_clk);
      `CHK("fault gates", 8'h00, bridge_gate)
      thermal_shutdown_event <= 1'b0;
      overcurrent_event <= 1'b0;
      repeat (6) @(posedge sys_clk);
      bus(1'b0, STATUS_OFS, '0, rd);
      `CHK("fault home", HOME_POS, rd[4:0])
      exp_pos = HOME_POS;
      step_chk(1'b1, RES_EIGHTH);
    end
  endtask : t_fault

  task automatic t_pin();
    host.hold_reset(1'b0);
    repeat (6) @(posedge sys_clk);
    `CHK("pin gates", 8'h00, bridge_gate)
    host.pulse();
    bus(1'b0, STATUS_OFS, '0, rd);
    `CHK("pin home", HOME_POS, rd[4:0])
    host.hold_reset(1'b1);
    repeat (6) @(posedge sys_clk);
    exp_pos = HOME_POS;
  endtask : t_pin

  task automatic t_enable();
    enable_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("disabled gates", 8'h00, bridge_gate)
    step_chk(1'b1, RES_EIGHTH);
    enable_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : t_enable

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    {sys_rst, enable_n, thermal_shutdown_event, overcurrent_event} = 4'h8;
    {otm, sense_trip, avs_address, avs_read, avs_write} = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    do_reset(OTM_VDD);
    `CHK("home cos", {7'h47, 1'b1, DEC_MIXED}, phase_out[0])
    `CHK("home sin", {7'h47, 1'b1, DEC_MIXED}, phase_out[1])
    meas_off(1171, 2579);
    for (int r = 0; r < 4; r++) step_chk(1'b1, r[1:0]);
    step_chk(1'b0, RES_EIGHTH);
    t_fault();
    t_pin();
    t_enable();
    do_reset(OTM_GND);
    meas_off(1171, 2579);
    step_chk(1'b1, RES_FULL);
    step_chk(1'b1, RES_EIGHTH);
    do_reset(OTM_RES);
    avs_byteenable <= 4'h2;
    bus(1'b1, CTRL_OFS, 32'h0000_ab01, rd);
    avs_byteenable <= 4'hf;
    bus(1'b0, CTRL_OFS, '0, rd);
    `CHK("byte lane", {8'hab, 8'(FIXED_OFF_TIME_US)}, rd[15:0])
    bus(1'b1, CTRL_OFS, 32'h0000_0001, rd);
    bus(1'b0, CTRL_OFS, '0, rd);
    `CHK("off time reg", 16'h0001, rd[15:0])
    bus(1'b0, 4'h2, '0, rd);
    `CHK("unmapped read", READ_ZERO, rd)
    meas_off(39, 86);
    step_chk(1'b0, RES_EIGHTH);
    meas_off(0, 125);
    conclude();
  end

endmodule : mst_translator_bench

`default_nettype wire
